// File: common/vga_attr_pkg.sv
// constants shared by the attribute controller and its helpers
// assumes one pixel clock and byte-wide host I/O
package vga_attr_pkg;
    // host I/O ports
    localparam logic [15:0] PORT_ATTR_WR    = 16'h03C0;
    localparam logic [15:0] PORT_ATTR_RD    = 16'h03C1;
    localparam logic [15:0] PORT_STAT_MONO  = 16'h03BA;
    localparam logic [15:0] PORT_STAT_COLOR = 16'h03DA;
    // register indexes
    localparam logic [4:0]  IDX_PAL_LAST = 5'h0F;
    localparam logic [4:0]  IDX_MODE     = 5'h10;
    localparam logic [4:0]  IDX_BORDER   = 5'h11;
    localparam logic [4:0]  IDX_PLANE    = 5'h12;
    localparam logic [4:0]  IDX_PAN      = 5'h13;
    localparam logic [4:0]  IDX_SEL      = 5'h14;
    // bit positions
    localparam int          ADDR_PAS        = 5;
    localparam int          MODE_PAL_SIZE   = 7;
    localparam int          MODE_PIX_SAMPLE = 6;
    localparam int          MODE_PAN_COMPAT = 5;
    localparam int          MODE_BLINK      = 3;
    localparam int          MODE_LINE_GFX   = 2;
    // writable and readable masks
    localparam logic [7:0]  ADDR_MASK    = 8'h3F;
    localparam logic [7:0]  PAL_MASK     = 8'h3F;
    localparam logic [7:0]  MODE_WR_MASK = 8'hEC;
    localparam logic [7:0]  MODE_RD_MASK = 8'hE4;
    localparam logic [7:0]  NIBBLE_MASK  = 8'h0F;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    // line graphics character range
    localparam logic [7:0]  LINE_CODE_LO = 8'hC0;
    localparam logic [7:0]  LINE_CODE_HI = 8'hDF;
    // pan limits
    localparam logic [3:0]  PAN_MAX      = 4'h7;
    localparam logic [3:0]  PAN_TEXT_ZERO = 4'h8;
    // pixel word layout
    localparam int          PIX_W        = 29;
    localparam int          W_BORDER     = 28;
    localparam int          W_LSTART     = 27;
    localparam int          W_DOT        = 26;
    localparam int          W_DOT8       = 25;
    localparam int          W_NINTH      = 24;
    localparam int          W_DATA       = 16;
    localparam int          W_ATTR       = 8;
    localparam int          W_CODE       = 0;
    // host write phase
    typedef enum logic [1:0] {PH_INDEX = 2'b01, PH_DATA = 2'b10} attr_phase_t;
endpackage

// File: rtl/attr_fifo.sv
// pixel word FIFO with registered ready flag
// assumes one clock; source honours inReady
`timescale 1ns/1ps
module attr_fifo
    import vga_attr_pkg::*;
#(
    parameter int WIDTH = PIX_W,
    parameter int DEPTH = 8
)(
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [CW-1:0]    count_q;
    logic             room_q;
    logic             push;
    logic             pop;

    assign push     = inValid && room_q;
    assign pop      = outValid && outReady;
    assign inReady  = room_q;
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

    // storage
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wrPtr_q] <= inData;
    end

    // pointers, count and full flag
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            room_q  <= 1'b1;
        end
        else
        begin
            if (push)
                wrPtr_q <= (wrPtr_q == LAST_PTR) ? '0 : wrPtr_q + 1'b1;
            if (pop)
                rdPtr_q <= (rdPtr_q == LAST_PTR) ? '0 : rdPtr_q + 1'b1;
            if (push && !pop)
            begin
                count_q <= count_q + 1'b1;
                room_q  <= (count_q != FULL_CNT - 1'b1);
            end
            else if (pop && !push)
            begin
                count_q <= count_q - 1'b1;
                room_q  <= 1'b1;
            end
        end
    end
endmodule

// File: rtl/attr_pan_drop.sv
// drops the first pixels of each line to pan left
// assumes lineStart marks the first pixel of a scan line
`timescale 1ns/1ps
module attr_pan_drop
    import vga_attr_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       step,
    input  wire logic       lineStart,
    input  wire logic [3:0] panValue,
    input  wire logic       textMode,
    input  wire logic       mode256,
    input  wire logic       panCompat,
    input  wire logic       lineCmp,
    output logic            drop
);
    logic [3:0] cnt_q;
    logic [3:0] shift;

    // pixels to skip for a pan value
    function automatic logic [3:0] panShift(input logic [3:0] v, input logic txt, input logic m256);
        if (v > PAN_MAX)
            panShift = 4'h0;
        else if (m256)
            panShift = {1'b0, v[3:1]};
        else if (txt)
            panShift = v + 4'h1;
        else
            panShift = v;
    endfunction

    // with the compat bit set, lower screen is not panned once line compare has hit
    assign shift = (panCompat && lineCmp) ? 4'h0 : panShift(panValue, textMode, mode256);
    assign drop  = step && (lineStart ? (shift != 4'h0) : (cnt_q != 4'h0));

    // remaining pixels to skip on this line
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            cnt_q <= 4'h0;
        else if (step && lineStart && shift != 4'h0)
            cnt_q <= shift - 4'h1;
        else if (step && !lineStart && cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_text_eight;
        step && lineStart && textMode && !mode256 && panValue == PAN_TEXT_ZERO |-> !drop;
    endproperty
    a_text_eight: assert property (p_text_eight) else $error("pan 8 in text mode dropped");

    property p_first_drop;
        step && lineStart && !(panCompat && lineCmp) && !textMode && !mode256
            && panValue != 4'h0 && panValue <= PAN_MAX |-> drop;
    endproperty
    a_first_drop: assert property (p_first_drop) else $error("panned line kept first pixel");

    property p_split_nopan;
        step && lineStart && panCompat && lineCmp |-> !drop;
    endproperty
    a_split_nopan: assert property (p_split_nopan) else $error("lower screen panned");
endmodule

// File: rtl/vga_attribute_controller.sv
// attribute controller: indexed host registers and pixel colour path
// assumes host strobes and pixel stream are on clk_sys
//
// What this block does
// - sixteen 6-bit maps replace 4-bit colour values
// - map bits: secondary RGB high, RGB low
// - palette size selects source of index 5:4
// - pixel sampling passes full 8-bit pixels
// - compat bit lets line compare stop panning
// - blink bit: attribute top bit blinks or intensifies
// - line graphics copies eighth dot to ninth
// - border pixels output border index
// - plane mask gates each plane, except in pixel sampling mode
// - pan count shifts video left per mode
// - select bits 3:2 give index 7:6
// - select bits 1:0 give index 5:4
// - indexes 0x00-0x14 via ports 3C0/3C1
// - flip-flop alternates index/data, status read clears
`timescale 1ns/1ps
module vga_attribute_controller
    import vga_attr_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)(
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic [15:0]      ioAddr,
    input  wire logic             ioWr,
    input  wire logic             ioRd,
    input  wire logic [7:0]       ioWdata,
    output logic      [7:0]       ioRdata,
    output logic                  ioRdValid,
    input  wire logic             pixValid,
    output logic                  pixReady,
    input  wire logic [PIX_W-1:0] pixWord,
    input  wire logic             textMode,
    input  wire logic             blinkPhase,
    input  wire logic             lineCmp,
    output logic      [7:0]       dacIndex,
    output logic                  dacValid,
    input  wire logic             dacReady
);
    //------------------------------------------------------------
    // register state
    //------------------------------------------------------------
    attr_phase_t phase_q;
    logic [5:0]  addr_q;
    logic [5:0]  pal_q [16];
    logic [7:0]  mode_q;
    logic [7:0]  border_q;
    logic [3:0]  plane_q;
    logic [3:0]  pan_q;
    logic [3:0]  sel_q;
    logic [7:0]  ioRdata_q;
    logic        ioRdValid_q;
    logic [7:0]  dacIndex_q;
    logic        dacValid_q;

    logic        wrAddrPort;
    logic        wrDataPort;
    logic        rdStatus;
    logic        regWr;
    logic [4:0]  regIdx;

    assign regIdx     = addr_q[4:0];
    assign wrAddrPort = ioWr && ioAddr == PORT_ATTR_WR;
    assign wrDataPort = ioWr && ioAddr == PORT_ATTR_RD;
    assign rdStatus   = ioRd && (ioAddr == PORT_STAT_MONO || ioAddr == PORT_STAT_COLOR);
    // data lands on 3C0 in data phase or on 3C1 directly
    assign regWr      = (wrAddrPort && phase_q == PH_DATA) || wrDataPort;

    // readback of one indexed register, reserved bits zero
    function automatic logic [7:0] regRead(input logic [4:0] idx);
        regRead = 8'h00;
        if (idx <= IDX_PAL_LAST)
            regRead = {2'b00, pal_q[idx[3:0]]} & PAL_MASK;
        else
            case (idx)
                IDX_MODE:   regRead = mode_q & MODE_RD_MASK;
                IDX_BORDER: regRead = border_q;
                IDX_PLANE:  regRead = {4'h0, plane_q};
                IDX_PAN:    regRead = {4'h0, pan_q};
                IDX_SEL:    regRead = {4'h0, sel_q};
                default:    regRead = 8'h00;
            endcase
    endfunction

    //------------------------------------------------------------
    // host access
    //------------------------------------------------------------
    // index/data flip-flop; a write in the clearing cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            phase_q <= PH_INDEX;
        else if (wrAddrPort)
            phase_q <= (phase_q == PH_INDEX) ? PH_DATA : PH_INDEX;
        else if (rdStatus)
            phase_q <= PH_INDEX;
    end

    // index register with palette source bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            addr_q <= 6'h00;
        else if (wrAddrPort && phase_q == PH_INDEX)
            addr_q <= ioWdata[5:0] & ADDR_MASK[5:0];
    end

    // colour map entries
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            for (int i = 0; i < 16; i++)
                pal_q[i] <= 6'h00;
        end
        else if (regWr && regIdx <= IDX_PAL_LAST)
            pal_q[regIdx[3:0]] <= ioWdata[5:0];
    end

    // control registers
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mode_q   <= RST_BYTE;
            border_q <= RST_BYTE;
            plane_q  <= 4'h0;
            pan_q    <= 4'h0;
            sel_q    <= 4'h0;
        end
        else if (regWr)
            case (regIdx)
                IDX_MODE:   mode_q   <= ioWdata & MODE_WR_MASK;
                IDX_BORDER: border_q <= ioWdata;
                IDX_PLANE:  plane_q  <= ioWdata[3:0];
                IDX_PAN:    pan_q    <= ioWdata[3:0];
                IDX_SEL:    sel_q    <= ioWdata[3:0];
                default:    ;
            endcase
    end

    // registered read answer, one cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ioRdata_q   <= 8'h00;
            ioRdValid_q <= 1'b0;
        end
        else
        begin
            ioRdValid_q <= ioRd && (ioAddr == PORT_ATTR_WR || ioAddr == PORT_ATTR_RD);
            if (ioRd && ioAddr == PORT_ATTR_WR)
                ioRdata_q <= {2'b00, addr_q};
            else if (ioRd && ioAddr == PORT_ATTR_RD)
                ioRdata_q <= regRead(regIdx);
        end
    end

    assign ioRdata   = ioRdata_q;
    assign ioRdValid = ioRdValid_q;

    //------------------------------------------------------------
    // pixel buffer and pan
    //------------------------------------------------------------
    logic             bufValid;
    logic             bufPop;
    logic [PIX_W-1:0] w;
    logic             drop;
    logic             take;
    logic             load;

    attr_fifo #(
        .WIDTH (PIX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .inValid  (pixValid),
        .inReady  (pixReady),
        .inData   (pixWord),
        .outValid (bufValid),
        .outReady (bufPop),
        .outData  (w)
    );

    // pop when the output stage can accept
    assign take   = !dacValid_q || dacReady;
    assign bufPop = bufValid && take;
    assign load   = bufPop && !drop;

    attr_pan_drop u_pan (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .step      (bufPop && !w[W_BORDER]),
        .lineStart (w[W_LSTART]),
        .panValue  (pan_q),
        .textMode  (textMode),
        .mode256   (mode_q[MODE_PIX_SAMPLE]),
        .panCompat (mode_q[MODE_PAN_COMPAT]),
        .lineCmp   (lineCmp),
        .drop      (drop)
    );

    //------------------------------------------------------------
    // colour path
    //------------------------------------------------------------
    logic [7:0] attr;
    logic [7:0] code;
    logic       lineCode;
    logic       dotOn;
    logic       blinkOff;
    logic [3:0] bgColour;
    logic [3:0] colour;
    logic [3:0] gated;
    logic [5:0] mapped;
    logic [7:0] index;

    assign attr     = w[W_ATTR +: 8];
    assign code     = w[W_CODE +: 8];
    assign lineCode = code >= LINE_CODE_LO && code <= LINE_CODE_HI;

    // ninth dot is background unless a line graphics code
    always_comb
    begin
        dotOn = w[W_DOT];
        if (w[W_NINTH])
            dotOn = mode_q[MODE_LINE_GFX] && lineCode && w[W_DOT8];
    end

    // top attribute bit: blink or background intensity
    assign blinkOff = mode_q[MODE_BLINK] && attr[7] && blinkPhase;
    assign bgColour = mode_q[MODE_BLINK] ? {1'b0, attr[6:4]} : attr[7:4];

    // text uses attribute nibbles, graphics uses plane bits
    always_comb
    begin
        if (textMode)
            colour = (dotOn && !blinkOff) ? attr[3:0] : bgColour;
        else
            colour = w[W_DATA +: 4];
    end

    assign gated  = colour & plane_q;
    assign mapped = pal_q[gated];

    // compose the DAC index
    always_comb
    begin
        if (w[W_BORDER])
            index = border_q;
        else if (mode_q[MODE_PIX_SAMPLE])
            index = w[W_DATA +: 8];
        else if (mode_q[MODE_PAL_SIZE])
            index = {sel_q[3:2], sel_q[1:0], mapped[3:0]};
        else
            index = {sel_q[3:2], mapped[5:4], mapped[3:0]};
    end

    // output stage holds while the DAC stalls
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            dacIndex_q <= 8'h00;
            dacValid_q <= 1'b0;
        end
        else if (take)
        begin
            dacValid_q <= load;
            if (load)
                dacIndex_q <= index;
        end
    end

    assign dacIndex = dacIndex_q;
    assign dacValid = dacValid_q;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_pix_load;
        load && !w[W_BORDER] && !mode_q[MODE_PIX_SAMPLE];
    endsequence

    property p_flip_toggle;
        wrAddrPort |=> phase_q != $past(phase_q);
    endproperty
    a_flip_toggle: assert property (p_flip_toggle) else $error("flip-flop did not toggle");

    property p_flip_clear;
        rdStatus && !wrAddrPort |=> phase_q == PH_INDEX;
    endproperty
    a_flip_clear: assert property (p_flip_clear) else $error("status read did not clear");

    property p_rd_reserved;
        ioRd && ioAddr == PORT_ATTR_RD && regIdx >= IDX_PLANE |=> ioRdValid && ioRdata[7:4] == 4'h0;
    endproperty
    a_rd_reserved: assert property (p_rd_reserved) else $error("reserved bits read nonzero");

    property p_pal_store;
        regWr && regIdx <= IDX_PAL_LAST ##1 ioRd && ioAddr == PORT_ATTR_RD && !regWr
            |=> ioRdata == {2'b00, $past(ioWdata[5:0], 2)};
    endproperty
    a_pal_store: assert property (p_pal_store) else $error("map entry readback wrong");

    property p_border;
        load && w[W_BORDER] |=> dacValid && dacIndex == $past(border_q);
    endproperty
    a_border: assert property (p_border) else $error("border index wrong");

    property p_hi_bits;
        s_pix_load |=> dacIndex[7:6] == $past(sel_q[3:2]);
    endproperty
    a_hi_bits: assert property (p_hi_bits) else $error("index 7:6 wrong");

    property p_mid_bits;
        s_pix_load ##0 mode_q[MODE_PAL_SIZE] |=> dacIndex[5:4] == $past(sel_q[1:0]);
    endproperty
    a_mid_bits: assert property (p_mid_bits) else $error("index 5:4 not from select");

    property p_map_bits;
        s_pix_load ##0 !mode_q[MODE_PAL_SIZE] |=> dacIndex[5:0] == $past(mapped);
    endproperty
    a_map_bits: assert property (p_map_bits) else $error("mapped colour wrong");

    property p_full_pixel;
        load && !w[W_BORDER] && mode_q[MODE_PIX_SAMPLE] |=> dacIndex == $past(w[W_DATA +: 8]);
    endproperty
    a_full_pixel: assert property (p_full_pixel) else $error("8-bit pixel altered");

    property p_stall;
        dacValid && !dacReady |=> dacValid && $stable(dacIndex);
    endproperty
    a_stall: assert property (p_stall) else $error("output changed under stall");
endmodule

// File: test/dac_sink.sv
// palette DAC stand-in: takes indexes, can stall or accept every other cycle
// assumes dacIndex and dacValid are registered on clk_sys
`timescale 1ns/1ps
module dac_sink (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [7:0] dacIndex,
    input  wire logic       dacValid,
    output logic            dacReady,
    input  wire logic       stall,
    input  wire logic       slow
);
    logic [7:0] seen[$];
    logic       phase    = 1'b0;
    logic       pend     = 1'b0;
    logic [7:0] prevIdx  = 8'h00;
    int         holdErrs = 0;

    initial dacReady = 1'b0;

    // ready pattern, changed off the sampling edge
    always @(negedge clk_sys)
    begin
        phase    <= ~phase;
        dacReady <= !srst && !stall && (!slow || phase);
    end

    // capture accepted pixels; an offer left waiting must not change
    always @(posedge clk_sys)
    begin
        if (!srst && dacValid && dacReady)
            seen.push_back(dacIndex);
        if (!srst && pend && (dacValid !== 1'b1 || dacIndex !== prevIdx))
            holdErrs++;
        pend    <= !srst && dacValid && !dacReady;
        prevIdx <= dacIndex;
    end
endmodule

// File: test/vga_attribute_controller_bench.sv
// self-checking bench for the attribute controller
// assumes dac_sink on the pixel output; inputs change on falling edges
`timescale 1ns/1ps
module vga_attribute_controller_bench;
    import vga_attr_pkg::*;
    localparam int LIMIT = 20000;
    logic             clk_sys    = 1'b0;
    logic             srst       = 1'b1;
    logic [15:0]      ioAddr     = 16'h0000;
    logic             ioWr       = 1'b0;
    logic             ioRd       = 1'b0;
    logic [7:0]       ioWdata    = 8'h00;
    logic [7:0]       ioRdata;
    logic             ioRdValid;
    logic             pixValid   = 1'b0;
    logic             pixReady;
    logic [PIX_W-1:0] pixWord    = '0;
    logic             lineCmp    = 1'b0;
    logic             textMode   = 1'b0;
    logic             blinkPhase = 1'b0;
    logic [7:0]       dacIndex;
    logic             dacValid;
    logic             dacReady;
    logic             stall      = 1'b0;
    logic             slow       = 1'b0;
    logic [7:0]       rv;
    int               fails      = 0;
    int               comparisons = 0;
    int               cycles     = 0;

    always #25 clk_sys = ~clk_sys;

    vga_attribute_controller #(.FIFO_DEPTH(8)) uut (.clk_sys(clk_sys), .srst(srst), .ioAddr(ioAddr),
        .ioWr(ioWr), .ioRd(ioRd), .ioWdata(ioWdata), .ioRdata(ioRdata), .ioRdValid(ioRdValid),
        .pixValid(pixValid), .pixReady(pixReady), .pixWord(pixWord), .textMode(textMode),
        .blinkPhase(blinkPhase), .lineCmp(lineCmp), .dacIndex(dacIndex), .dacValid(dacValid), .dacReady(dacReady));
    dac_sink dac (.clk_sys(clk_sys), .srst(srst), .dacIndex(dacIndex), .dacValid(dacValid),
        .dacReady(dacReady), .stall(stall), .slow(slow));

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            conclude();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        ioAddr = a;
        ioWdata = d;
        ioWr = 1'b1;
        @(negedge clk_sys);
        ioWr = 1'b0;
    endtask

    // read right after a write; answer stands at the next falling edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        ioAddr = a;
        ioRd = 1'b1;
        @(negedge clk_sys);
        ioRd = 1'b0;
        chk({7'h00, ioRdValid}, 8'h01);
        d = ioRdata;
    endtask

    // status read puts the flip-flop in index phase
    task automatic clrFlop;
        @(negedge clk_sys);
        ioAddr = PORT_STAT_COLOR;
        ioRd = 1'b1;
        @(negedge clk_sys);
        ioRd = 1'b0;
    endtask

    task automatic setReg(input logic [4:0] i, input logic [7:0] v);
        clrFlop();
        wr(PORT_ATTR_WR, {3'b000, i});
        wr(PORT_ATTR_WR, v);
    endtask

    task automatic getReg(input logic [4:0] i, output logic [7:0] v);
        clrFlop();
        wr(PORT_ATTR_WR, {3'b000, i});
        rd(PORT_ATTR_RD, v);
    endtask

    task automatic dispOn;
        clrFlop();
        wr(PORT_ATTR_WR, 8'h20);
    endtask

    function automatic logic [5:0] palv(input int n);
        return 6'(n * 5 + 3);
    endfunction

    function automatic logic [7:0] expIdx(input logic [3:0] nib, input logic palette_size_select, input logic [3:0] sel,
                                          input logic [3:0] mask);
        logic [5:0] p;
        p = palv(int'(nib & mask));
        return {sel[3:2], palette_size_select ? sel[1:0] : p[5:4], p[3:0]};
    endfunction

    task automatic px(input logic [PIX_W-1:0] wd);
        int n;
        @(negedge clk_sys);
        for (n = 0; n < 50 && pixReady !== 1'b1; n++)
            @(negedge clk_sys);
        pixWord = wd;
        pixValid = 1'b1;
        @(negedge clk_sys);
        pixValid = 1'b0;
    endtask

    task automatic expOut(input logic [7:0] e);
        int n;
        for (n = 0; n < 300 && dac.seen.size() == 0; n++)
            @(negedge clk_sys);
        chk(dac.seen.size() > 0 ? dac.seen.pop_front() : 8'hXX, e);
    endtask

    // one line of five pixels, the first k expected dropped
    task automatic panLine(input int k);
        int n;
        for (n = 1; n <= 5; n++)
            px({1'b0, n == 1, 7'h00, 4'(n), 16'h0741});
        for (n = k + 1; n <= 5; n++)
            expOut(expIdx(4'(n), 1'b0, 4'h9, 4'hF));
        repeat (20) @(negedge clk_sys);
        chk(8'(dac.seen.size()), 8'h00);
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic regScen;
        int i;
        logic [7:0] rexp [4];
        rexp = '{8'hFF, 8'h0F, 8'h0F, 8'h0F};
        getReg(IDX_BORDER, rv);
        chk(rv, RST_BYTE);
        // palette loaded while the pixel stream is idle
        for (i = 0; i < 16; i++)
            setReg(5'(i), {2'b11, palv(i)});
        for (i = 0; i < 16; i++)
        begin
            getReg(5'(i), rv);
            chk(rv, {2'b00, palv(i)});
        end
        setReg(IDX_MODE, 8'hFF);
        getReg(IDX_MODE, rv);
        chk(rv, 8'hE4);
        setReg(IDX_MODE, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            setReg(IDX_BORDER + 5'(i), 8'hFF);
            getReg(IDX_BORDER + 5'(i), rv);
            chk(rv, rexp[i]);
        end
        setReg(5'h15, 8'hFF);
        getReg(5'h15, rv);
        chk(rv, 8'h00);
        // index, data, index again on the shared port
        clrFlop();
        wr(PORT_ATTR_WR, 8'h02);
        rd(PORT_ATTR_WR, rv);
        chk(rv, 8'h02);
        wr(PORT_ATTR_WR, {2'b11, palv(2)});
        rd(PORT_ATTR_RD, rv);
        chk(rv, {2'b00, palv(2)});
        wr(PORT_ATTR_WR, 8'h13);
        rd(PORT_ATTR_WR, rv);
        chk(rv, 8'h13);
    endtask

    task automatic colourScen;
        int i;
        slow = 1'b1;
        setReg(IDX_PLANE, 8'h0F);
        setReg(IDX_SEL, 8'h09);
        setReg(IDX_PAN, 8'h00);
        dispOn();
        for (i = 0; i < 16; i++)
        begin
            px({9'h000, 4'(i), 16'h0741});
            expOut(expIdx(4'(i), 1'b0, 4'h9, 4'hF));
        end
        setReg(IDX_MODE, 8'h80);
        px({9'h000, 4'h3, 16'h0741});
        expOut(expIdx(4'h3, 1'b1, 4'h9, 4'hF));
        px({9'h000, 4'hC, 16'h0741});
        expOut(expIdx(4'hC, 1'b1, 4'h9, 4'hF));
        setReg(IDX_MODE, 8'h00);
        setReg(IDX_PLANE, 8'h05);
        px({9'h000, 4'hF, 16'h0741});
        expOut(expIdx(4'hF, 1'b0, 4'h9, 4'h5));
        setReg(IDX_PLANE, 8'h0F);
        setReg(IDX_BORDER, 8'hA7);
        px({9'h100, 4'h5, 16'h0741});
        expOut(8'hA7);
        slow = 1'b0;
    endtask

    task automatic panScen;
        setReg(IDX_PAN, 8'h03);
        panLine(3);
        setReg(IDX_PAN, 8'h08);
        panLine(0);
        setReg(IDX_PAN, 8'h02);
        setReg(IDX_MODE, 8'h20);
        lineCmp = 1'b1;
        panLine(0);
        lineCmp = 1'b0;
        panLine(2);
        setReg(IDX_MODE, 8'h00);
        setReg(IDX_PAN, 8'h00);
    endtask

    task automatic txt(input logic [PIX_W-1:0] wd, input logic [3:0] c);
        px(wd);
        expOut(expIdx(c, 1'b0, 4'h9, 4'hF));
    endtask

    // text cells: intensity, blink-off and ninth dot
    task automatic textScen;
        textMode = 1'b1;
        blinkPhase = 1'b1;
        setReg(IDX_PAN, 8'h08);
        txt({5'b01000, 8'h00, 8'h9C, 8'h41}, 4'h9);
        setReg(IDX_MODE, 8'h0C);
        txt({5'b00100, 8'h00, 8'h9C, 8'h41}, 4'h1);
        txt({5'b00011, 8'h00, 8'h2C, 8'hC4}, 4'hC);
        textMode = 1'b0;
    endtask

    task automatic fifoScen;
        int n;
        int acc;
        acc = 0;
        stall = 1'b1;
        @(negedge clk_sys);
        pixWord = {5'b00000, 4'h0, 4'h6, 8'h07, 8'h41};
        for (n = 0; n < 20 && pixReady === 1'b1; n++)
        begin
            pixValid = 1'b1;
            acc++;
            @(negedge clk_sys);
        end
        pixValid = 1'b0;
        chk({7'h00, pixReady}, 8'h00);
        chk({7'h00, acc >= 8 && acc <= 10}, 8'h01);
        stall = 1'b0;
        slow = 1'b1;
        for (n = 0; n < acc; n++)
            expOut(expIdx(4'h6, 1'b0, 4'h9, 4'hF));
        repeat (20) @(negedge clk_sys);
        chk(8'(dac.seen.size()), 8'h00);
        chk({7'h00, pixReady}, 8'h01);
        slow = 1'b0;
    endtask

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial
    begin
        repeat (20) @(negedge clk_sys);
        srst = 1'b0;
        chk(ioRdata, 8'h00);
        chk({6'h00, dacValid, pixReady}, 8'h01);
        regScen();
        colourScen();
        panScen();
        textScen();
        fifoScen();
        chk(8'(dac.holdErrs), 8'h00);
        conclude();
    end
endmodule
